/* File: logic/unbrx_pkg.sv */
// Shared constants and types for the nine-bit UART receiver and its baud generator
// Functional notes
// - Start on falling edge, sampled at 16x
// - Start loads 1FFh, clears bit counter
// - Majority of samples at states 7-9
// - Nonzero start bit aborts, search again
// - Shift left; start at MSB ends frame
// - Complete if filter off or ninth=1, flag clear
// - Ninth bit, byte stored, done flag set
// - Else drop frame; rearm one bit later
// - Stop bit value affects nothing
// - Fixed rate is 2^doubler times osc/64
// - Timer1 rate 2^doubler times overflow/32
// - Timer2 generator needs both selects set
// - Timer2 counts osc/2, reloads on overflow
// - Timer2 rate osc/(32*(65536-reload))
// - Timer2 overflow sets no flag/interrupt
// - Both selects clear: timer1 is source
// - Frame: start, 8 data LSB first, ninth, stop
// - Variable mode equals fixed mode otherwise
package unbrx_pkg;

    // Receive shift register
    localparam int         SHREG_W      = 9;
    localparam logic [8:0] SHREG_INIT   = 9'h1FF;
    localparam int         DATA_W       = 8;

    // Divide-by-16 bit-time counter
    localparam int         CNT_W        = 4;
    localparam logic [3:0] CNT_CLEAR    = 4'h0;
    localparam logic [3:0] CNT_SAMP_A   = 4'h7;
    localparam logic [3:0] CNT_SAMP_B   = 4'h8;
    localparam logic [3:0] CNT_SAMP_C   = 4'h9;

    // Fixed rate: 16x tick every 4 clocks, or 2 when doubled
    localparam logic [1:0] FIX_LAST     = 2'h3;
    localparam logic [1:0] FIX_LAST_DBL = 2'h1;

    // Timer 1: counts once per 12 clocks, 8-bit auto reload
    localparam logic [3:0] T1_PRE_LAST  = 4'hB;
    localparam logic [7:0] T1_TOP       = 8'hFF;

    // Timer 2: counts once per 2 clocks, 16-bit reload
    localparam logic [15:0] T2_TOP      = 16'hFFFF;

    // Received word FIFO
    localparam int         FIFO_W       = 9;
    localparam int         FIFO_D       = 16;

    // Receiver states
    typedef enum logic [1:0] {
        UNBRX_IDLE = 2'b00,
        UNBRX_RECV = 2'b01,
        UNBRX_HOLD = 2'b10
    } unbrx_state_t;

endpackage

/* File: logic/unbrx_fifo_if.sv */
// Carrier between the receiver and its word FIFO
`timescale 1ns/1ps
interface unbrx_fifo_if #(
    parameter int W = 9
);
    logic         push_valid;  // Word offered
    logic         push_ready;  // Room for a word
    logic [W-1:0] push_data;   // Offered word
    logic         pop_valid;   // Word available
    logic         pop_ready;   // Word taken
    logic [W-1:0] pop_data;    // Head word

    // FIFO end
    modport store (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data);
    // Receiver end
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface

/* File: logic/unbrx_fifo.sv */
// Synchronous word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module unbrx_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic     sys_clk_i,
    input  wire logic     nrst_i,
    // Both sides of the queue
    unbrx_fifo_if.store   fifo
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;    // Storage
        logic [AW-1:0]       wr;     // Write pointer
        logic [AW-1:0]       rd;     // Read pointer
        logic [AW:0]         count;  // Words held
    } unbrx_fifo_st_t;

    unbrx_fifo_st_t q;  // Registered state
    unbrx_fifo_st_t d;  // Next state
    logic           do_push;
    logic           do_pop;

    // Handshakes and next state
    always_comb begin
        d       = q;
        do_push = fifo.push_valid && (q.count != (AW+1)'(D));
        do_pop  = fifo.pop_ready && (q.count != '0);
        // Store a word
        if (do_push) begin
            d.mem[q.wr] = fifo.push_data;
            d.wr        = q.wr + 1'b1;
        end
        // Drop the head word
        if (do_pop) begin
            d.rd = q.rd + 1'b1;
        end
        // Track fill level
        if (do_push && !do_pop) begin
            d.count = q.count + 1'b1;
        end else if (do_pop && !do_push) begin
            d.count = q.count - 1'b1;
        end
    end

    assign fifo.push_ready = (q.count != (AW+1)'(D));
    assign fifo.pop_valid  = (q.count != '0);
    assign fifo.pop_data   = q.mem[q.rd];

    // State register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

/* File: logic/unbrx_top.sv */
// Nine-bit UART receive path with fixed, timer-1 and timer-2 baud sources
`timescale 1ns/1ps
module unbrx_top (
    // Clock and reset
    input  wire logic                         sys_clk_i,
    input  wire logic                         nrst_i,
    // Serial line
    input  wire logic                         rx_pin_i,
    // Mode and filter configuration
    input  wire logic                         variable_rate_i,
    input  wire logic                         baud_doubler_i,
    input  wire logic                         multiproc_filter_enable_i,
    input  wire logic                         receive_done_clear_i,
    // Timer 1 configuration
    input  wire logic                         timer1_run_i,
    input  wire logic [7:0]                   timer1_reload_byte_i,
    // Timer 2 configuration
    input  wire logic                         timer2_run_bit_i,
    input  wire logic                         transmit_clock_select_i,
    input  wire logic                         receive_clock_select_i,
    input  wire logic [7:0]                   timer2_reload_high_i,
    input  wire logic [7:0]                   timer2_reload_low_i,
    // Software-visible receive state
    output logic [unbrx_pkg::DATA_W-1:0]      serial_buffer_o,
    output logic                              received_ninth_bit_o,
    output logic                              receive_done_flag_o,
    // Received word stream
    output logic [unbrx_pkg::FIFO_W-1:0]      rx_word_o,
    output logic                              rx_word_valid_o,
    input  wire logic                         rx_word_ready_i
);
    import unbrx_pkg::*;

    // Overview of operation
    // One clock drives everything; the pin is taken as synchronous
    // A single 16x sample tick paces the receiver
    // Tick source chosen by variable_rate_i and the two clock selects
    // Fixed mode: tick every 4 clocks, every 2 when doubled
    // Timer 1: prescale by 12, 8-bit count, reload on overflow
    // Timer 1 overflow halved into a tick unless doubled
    // Timer 2: count every second clock, 16-bit reload on overflow
    // Timer 2 overflow is one tick; it raises no flag of its own
    // Timer 2 held at its reload while stopped or not selected
    // So the first period after start is a full reload period
    // Receiver idle: watches for a falling edge between two ticks
    // Edge found: register preset to all ones, counter cleared
    // Each bit: samples at counter states 7, 8 and 9
    // Vote at state 9: two of three samples decide the bit
    // Start bit voted high: back to idle, line history set high
    // Valid bits shift in from the right, ones leave on the left
    // Start bit at the top position marks the ninth data bit
    // Final shift: frame kept if filter off or ninth bit high
    // Frame also needs the done flag clear to be kept
    // Kept frame: buffer, ninth bit and done flag updated
    // Kept frame: one word pushed into the FIFO as well
    // Dropped frame: no flag change and no word
    // One bit time after the final shift: back to idle
    // Stop bit level never changes buffer, ninth bit or flag
    // Done flag is sticky until receive_done_clear_i
    // Clear and set in one cycle: set wins
    // Stream side: FIFO of 16 words plus one output register
    // FIFO full: new start edges ignored until room appears
    // Output register holds its word until ready is seen
    // Hazards and limits
    // No input synchroniser: pin must already be in this domain
    // Mixed clock selects fall back to timer 1
    // Changing the source mid-frame corrupts that frame
    // Timer 1 free-runs while timer1_run_i is high
    // Reload inputs are read at overflow; timer 2 also loads its reload while stopped or not selected
    // Rate changes take effect at the next overflow
    // All outputs are flip-flops of the state struct
    // Whole state is one packed struct, one next-state copy
    // Reset puts the receiver idle with a high line history
    // Shift register resets to all ones, as after a preset
    // Everything else resets to zero

    // Whole state of the block
    typedef struct packed {
        unbrx_state_t        state;      // Receiver state
        logic [CNT_W-1:0]    cnt;        // Divide-by-16 counter
        logic                prev;       // Pin level at last tick
        logic                samp_a;     // Sample at state 7
        logic                samp_b;     // Sample at state 8
        logic                first;      // Next bit is the start bit
        logic [SHREG_W-1:0]  shreg;      // Input shift register
        logic [DATA_W-1:0]   serial_buffer;       // Serial buffer
        logic                ninth;      // Received ninth bit
        logic                done;       // Receive-done flag
        logic                tick;       // 16x sample tick
        logic [1:0]          fix_div;    // Fixed-rate divider
        logic [3:0]          t1_pre;     // Timer 1 prescaler
        logic [7:0]          t1_cnt;     // Timer 1 count low byte
        logic                t1_half;    // Overflow halver
        logic                t2_pre;     // Timer 2 prescaler
        logic [15:0]         t2_cnt;     // Timer 2 count
        logic                out_valid;  // Stream output valid
        logic [FIFO_W-1:0]   out_data;   // Stream output word
    } unbrx_st_t;

    unbrx_st_t q;          // Registered state
    unbrx_st_t d;          // Next state
    logic      t2_gen;     // Timer 2 is the baud generator
    logic      t1_ovf;     // Timer 1 overflow this cycle
    logic      t2_ovf;     // Timer 2 overflow this cycle
    logic      majority;   // Voted bit value
    logic      final_sh;   // This sample is the final shift
    logic      accept;     // Frame passes completion checks
    logic [DATA_W-1:0] byte_rev;  // Data byte in LSB order

    // FIFO carrier
    unbrx_fifo_if #(.W(FIFO_W)) fq ();

    // Word FIFO between completed frames and the stream port
    unbrx_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .fifo      (fq.store)
    );

    // Byte reordering, first received bit to bit 0
    // LSB first into bit 0
    for (genvar i = 0; i < DATA_W; i++) begin : g_rev
        assign byte_rev[i] = q.shreg[DATA_W-1-i];
    end

    // Baud source selection and sample tick generation
    always_comb begin
        t2_gen = transmit_clock_select_i && receive_clock_select_i;
        t1_ovf = 1'b0;
        t2_ovf = 1'b0;
        d      = q;
        d.tick = 1'b0;

        if (q.fix_div == (baud_doubler_i ? FIX_LAST_DBL : FIX_LAST)) begin
            d.fix_div = 2'h0;
        end else begin
            d.fix_div = q.fix_div + 2'h1;
        end

        // Timer 1, one count per 12 clocks
        if (timer1_run_i) begin
            if (q.t1_pre == T1_PRE_LAST) begin
                d.t1_pre = 4'h0;
                // Auto reload from the reload byte
                if (q.t1_cnt == T1_TOP) begin
                    d.t1_cnt = timer1_reload_byte_i;
                    t1_ovf   = 1'b1;
                end else begin
                    d.t1_cnt = q.t1_cnt + 8'h01;
                end
            end else begin
                d.t1_pre = q.t1_pre + 4'h1;
            end
        end

        // timer 2 counts at half clock
        if (timer2_run_bit_i && t2_gen) begin
            d.t2_pre = ~q.t2_pre;
            if (q.t2_pre) begin
                // Overflow reloads, no flag raised
                // no overflow flag exists
                if (q.t2_cnt == T2_TOP) begin
                    d.t2_cnt = {timer2_reload_high_i, timer2_reload_low_i};
                    t2_ovf   = 1'b1;
                end else begin
                    d.t2_cnt = q.t2_cnt + 16'h0001;
                end
            end
        end else begin
            // Stopped: preset to reload, so the first period is full
            d.t2_pre = 1'b0;
            d.t2_cnt = {timer2_reload_high_i, timer2_reload_low_i};
        end

        // Tick selection per source
        // same receiver for every rate
        // timer 1 unless both selects set
        if (!variable_rate_i) begin
            d.tick = (q.fix_div == (baud_doubler_i ? FIX_LAST_DBL : FIX_LAST));
        end else if (t2_gen) begin
            // one tick per timer 2 overflow
            d.tick = t2_ovf;
        end else if (t1_ovf) begin
            d.t1_half = ~q.t1_half;
            d.tick    = baud_doubler_i || q.t1_half;
        end

        // Receiver defaults
        majority = (q.samp_a & q.samp_b) | (q.samp_a & rx_pin_i) | (q.samp_b & rx_pin_i);
        final_sh = ~q.shreg[SHREG_W-1];
        accept   = (!multiproc_filter_enable_i || majority) && !q.done;

        // Push strobe only at a kept final shift
        fq.push_valid = 1'b0;
        // Word is always ninth bit over data byte
        fq.push_data  = {majority, byte_rev};

        if (receive_done_clear_i) begin
            d.done = 1'b0;
        end

        // Receiver, advancing on each tick
        if (q.tick) begin
            d.cnt  = q.cnt + 4'h1;
            d.prev = rx_pin_i;
            case (q.state)
                UNBRX_IDLE: begin
                    if (q.prev && !rx_pin_i && fq.push_ready) begin
                        d.shreg = SHREG_INIT;
                        d.cnt   = CNT_CLEAR;
                        d.first = 1'b1;
                        d.state = UNBRX_RECV;
                    end
                end
                UNBRX_RECV: begin
                    // samples at states 7 and 8
                    if (q.cnt == CNT_SAMP_A) begin
                        d.samp_a = rx_pin_i;
                    end
                    if (q.cnt == CNT_SAMP_B) begin
                        d.samp_b = rx_pin_i;
                    end
                    if (q.cnt == CNT_SAMP_C) begin
                        d.first = 1'b0;
                        if (q.first && majority) begin
                            d.state = UNBRX_IDLE;
                            d.prev  = 1'b1;
                        end else if (final_sh) begin
                            d.shreg = {q.shreg[SHREG_W-2:0], majority};
                            d.state = UNBRX_HOLD;
                            if (accept) begin
                                d.serial_buffer        = byte_rev;
                                d.ninth       = majority;
                                d.done        = 1'b1;
                                fq.push_valid = 1'b1;
                            end
                        end else begin
                            d.shreg = {q.shreg[SHREG_W-2:0], majority};
                        end
                    end
                end
                UNBRX_HOLD: begin
                    // stop bit level is not used
                    if (q.cnt == CNT_SAMP_C) begin
                        d.state = UNBRX_IDLE;
                        d.prev  = rx_pin_i;
                    end
                end
                default: begin
                    d.state = UNBRX_IDLE;
                end
            endcase
        end

        // Output stage fed from the FIFO head
        fq.pop_ready = !q.out_valid || rx_word_ready_i;
        if (fq.pop_ready) begin
            d.out_valid = fq.pop_valid;
            d.out_data  = fq.pop_data;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q       <= '0;
            q.state <= UNBRX_IDLE;
            q.prev  <= 1'b1;
            q.shreg <= SHREG_INIT;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    // Software-visible receive state
    assign serial_buffer_o      = q.serial_buffer;
    assign received_ninth_bit_o = q.ninth;
    assign receive_done_flag_o  = q.done;
    // Stream port
    assign rx_word_o            = q.out_data;
    assign rx_word_valid_o      = q.out_valid;
endmodule

/* File: testbench/unbrx_top_props.sv */
// Concurrent checks on the receiver top ports
`timescale 1ns/1ps
module unbrx_top_props (
    // Clock and reset
    input wire logic                         sys_clk_i,
    input wire logic                         nrst_i,
    // Inputs watched
    input wire logic                         rx_pin_i,
    input wire logic                         multiproc_filter_enable_i,
    input wire logic                         receive_done_clear_i,
    input wire logic                         rx_word_ready_i,
    // Outputs watched
    input wire logic [unbrx_pkg::DATA_W-1:0] serial_buffer_o,
    input wire logic                         received_ninth_bit_o,
    input wire logic                         receive_done_flag_o,
    input wire logic [unbrx_pkg::FIFO_W-1:0] rx_word_o,
    input wire logic                         rx_word_valid_o
);
    import unbrx_pkg::*;
    // Clocks since the line was last low
    logic [12:0] high_q;
    // Saturating count, so a frame needs a recent low start bit
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            high_q <= 13'h0;
        end else if (!rx_pin_i) begin
            high_q <= 13'h0;
        end else if (high_q != 13'h1FFF) begin
            high_q <= high_q + 13'h1;
        end
    end
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    flag_holds_a: assert property (
        receive_done_flag_o && !receive_done_clear_i |=> receive_done_flag_o)
        else $error("done flag fell without clear");
    flag_clears_a: assert property (
        receive_done_flag_o && receive_done_clear_i |=> !receive_done_flag_o)
        else $error("done flag ignored clear");
    buffer_frozen_a: assert property (
        receive_done_flag_o |=> $stable(serial_buffer_o) && $stable(received_ninth_bit_o))
        else $error("buffer changed while flag set");
    filter_pass_a: assert property (
        $rose(receive_done_flag_o) && multiproc_filter_enable_i |-> received_ninth_bit_o)
        else $error("filtered frame with ninth bit low kept");
    buffer_cause_a: assert property (
        !$stable(serial_buffer_o) |-> $rose(receive_done_flag_o))
        else $error("buffer loaded without done flag");
    word_follows_a: assert property (
        $rose(receive_done_flag_o) && !rx_word_valid_o |-> ##[1:3]
        (rx_word_valid_o && rx_word_o == {received_ninth_bit_o, serial_buffer_o}))
        else $error("stream word missing or wrong");
    word_stands_a: assert property (
        rx_word_valid_o && !rx_word_ready_i |=> rx_word_valid_o && $stable(rx_word_o))
        else $error("stream word dropped before taken");
    start_needed_a: assert property (
        $rose(receive_done_flag_o) |-> high_q < 13'hFA0)
        else $error("frame accepted without start bit");
    cover property ($rose(receive_done_flag_o) && multiproc_filter_enable_i);
    cover property (rx_word_valid_o && rx_word_ready_i);
    cover property (receive_done_flag_o && receive_done_clear_i);
endmodule
bind unbrx_top unbrx_top_props unbrx_top_props_inst (.sys_clk_i, .nrst_i, .rx_pin_i,
    .multiproc_filter_enable_i, .receive_done_clear_i, .rx_word_ready_i,
    .serial_buffer_o, .received_ninth_bit_o, .receive_done_flag_o, .rx_word_o,
    .rx_word_valid_o);

/* File: testbench/unbrx_tx_model.sv */
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module unbrx_tx_model (
    // Clock
    input  wire logic        sys_clk_i,
    // Frame request
    input  wire logic        go_i,
    input  wire logic        glitch_i,
    input  wire logic [15:0] bit_clks_i,
    input  wire logic [10:0] frame_i,
    // Line and status
    output logic             tx_o,
    output logic             busy_o
);
    // One frame per request, then one idle bit
    initial begin
        tx_o = 1'b1;
        busy_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                if (glitch_i) begin
                    // short low, not a start bit
                    tx_o <= 1'b0;
                    repeat (bit_clks_i / 4) @(posedge sys_clk_i);
                    tx_o <= 1'b1;
                    repeat (bit_clks_i * 12) @(posedge sys_clk_i);
                end else begin
                    // start, data LSB first, ninth, stop
                    for (int i = 0; i < 11; i++) begin
                        tx_o <= frame_i[i];
                        repeat (bit_clks_i) @(posedge sys_clk_i);
                    end
                end
                tx_o <= 1'b1;
                repeat (bit_clks_i) @(posedge sys_clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule

/* File: testbench/unbrx_top_bench.sv */
// Self-checking bench for the nine-bit receiver top
`timescale 1ns/1ps
module unbrx_top_bench;
    import unbrx_pkg::*;
    // Clock, reset and mode inputs
    logic        clk = 1'b0, nrst = 1'b0, vr = 1'b0, dbl = 1'b0, filt = 1'b0;
    logic        clr = 1'b0, t1run = 1'b1, t2run = 1'b0, tsel = 1'b0, rsel = 1'b0;
    logic        rdy = 1'b1, go = 1'b0, glitch = 1'b0;
    // reloads fixed for the whole run
    logic [7:0]  t1rel = 8'hFF, t2relh = 8'hFF, t2rell = 8'hFD;
    // Outputs and line
    logic [7:0]  serial_buffer;
    logic [8:0]  word;
    logic        n9, done, wvalid, line, busy;
    logic [15:0] bitc = 16'h40;
    logic [10:0] frm = 11'h7FF;
    int          failures = 0, n_checks = 0;
    unbrx_top unbrx_top_inst (.sys_clk_i(clk), .nrst_i(nrst), .rx_pin_i(line),
        .variable_rate_i(vr), .baud_doubler_i(dbl), .multiproc_filter_enable_i(filt),
        .receive_done_clear_i(clr), .timer1_run_i(t1run), .timer1_reload_byte_i(t1rel),
        .timer2_run_bit_i(t2run), .transmit_clock_select_i(tsel),
        .receive_clock_select_i(rsel), .timer2_reload_high_i(t2relh),
        .timer2_reload_low_i(t2rell), .serial_buffer_o(serial_buffer), .received_ninth_bit_o(n9),
        .receive_done_flag_o(done), .rx_word_o(word), .rx_word_valid_o(wvalid),
        .rx_word_ready_i(rdy));
    unbrx_tx_model unbrx_tx_model_inst (.sys_clk_i(clk), .go_i(go), .glitch_i(glitch),
        .bit_clks_i(bitc), .frame_i(frm), .tx_o(line), .busy_o(busy));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Count one comparison, report a mismatch
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and stop
    task automatic end_of_test;
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Pick source and doubler as {variable, doubler, tx select, rx select}
    task automatic cfg(input logic [3:0] m);
        @(posedge clk);
        {vr, dbl, tsel, rsel} <= m;
        repeat (8) @(posedge clk);
    endtask
    // Bit length in clocks for a source setting
    function automatic int bit_len(input logic [3:0] m);
        if (!m[3]) return 64 >> m[2];
        if (m[1] && m[0]) return 32 * (65536 - int'({t2relh, t2rell}));
        return (384 * (256 - int'(t1rel))) >> m[2];
    endfunction
    // Send one frame and wait for the model to finish
    task automatic send(input logic [7:0] d, input logic n, s, g, input int bc);
        int k;
        @(posedge clk);
        frm <= {s, n, d, 1'b0};
        glitch <= g;
        bitc <= 16'(bc);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 9000 && busy; k++) @(posedge clk);
    endtask
    // Flag, buffer and ninth bit against expectation
    task automatic expect_rx(input logic a, input logic [7:0] d, input logic n);
        chk("done flag", 16'(done), 16'(a));
        chk("serial buffer", 16'(serial_buffer), 16'(d));
        chk("ninth bit", 16'(n9), 16'(n));
    endtask
    // Pulse clear and see the flag drop
    task automatic clear;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        chk("flag cleared", 16'(done), 16'h0);
    endtask
    // Fixed rate frames, second with a low stop bit
    task automatic t_fixed;
        cfg(4'b0000);
        send(8'hA5, 1'b1, 1'b1, 1'b0, 64);
        expect_rx(1'b1, 8'hA5, 1'b1);
        clear;
        send(8'h3C, 1'b0, 1'b0, 1'b0, 64);
        expect_rx(1'b1, 8'h3C, 1'b0);
        send(8'h5A, 1'b1, 1'b1, 1'b0, 64);
        expect_rx(1'b1, 8'h3C, 1'b0);
        clear;
    endtask
    // Filter drops ninth-low frames, keeps ninth-high
    task automatic t_filter;
        @(posedge clk);
        filt <= 1'b1;
        send(8'h11, 1'b0, 1'b1, 1'b0, 64);
        expect_rx(1'b0, 8'h3C, 1'b0);
        send(8'h22, 1'b1, 1'b1, 1'b0, 64);
        expect_rx(1'b1, 8'h22, 1'b1);
        clear;
        filt <= 1'b0;
    endtask
    // Short low pulse rejected, next frame still taken
    task automatic t_false;
        send(8'h00, 1'b0, 1'b1, 1'b1, 64);
        expect_rx(1'b0, 8'h22, 1'b1);
        send(8'h81, 1'b1, 1'b1, 1'b0, 64);
        expect_rx(1'b1, 8'h81, 1'b1);
        clear;
    endtask
    // Each rate source; timer 2 selected but halted hears nothing
    task automatic t_rates;
        logic [3:0] m [5] = '{4'b0100, 4'b1100, 4'b1000, 4'b1110, 4'b1111};
        for (int i = 0; i < 5; i++) begin
            cfg(m[i]);
            send(8'(8'h40 + i), 1'b1, 1'b1, 1'b0, bit_len(m[i]));
            expect_rx(1'(i < 4), 8'(8'h40 + (i < 4 ? i : 3)), 1'b1);
            clear;
        end
        t2run <= 1'b1;
        cfg(4'b1111);
        send(8'h45, 1'b0, 1'b1, 1'b0, bit_len(4'b1111));
        expect_rx(1'b1, 8'h45, 1'b0);
        clear;
        t2run <= 1'b0;
    endtask
    // Stall the stream until frames are refused, then drain in order
    task automatic t_fifo;
        logic acc [18];
        int k;
        cfg(4'b0100);
        rdy <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            send(8'(8'h10 + i), i[0], 1'b1, 1'b0, 32);
            acc[i] = done;
            clear;
        end
        chk("refused when full", 16'(acc[17]), 16'h0);
        for (int i = 0; i < 18; i++) begin
            if (i < 16) chk("accepted", 16'(acc[i]), 16'h1);
            if (acc[i]) begin
                for (k = 0; k < 10 && wvalid !== 1'b1; k++) @(posedge clk);
                chk("word", 16'(word), 16'({i[0], 8'(8'h10 + i)}));
                rdy <= 1'b1;
                @(posedge clk);
                rdy <= 1'b0;
                @(posedge clk);
            end
        end
        repeat (4) @(posedge clk);
        chk("stream empty", 16'(wvalid), 16'h0);
    endtask
    // Reset for 12 cycles, then run every scenario
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_fixed;
        t_filter;
        t_false;
        t_rates;
        t_fifo;
        end_of_test;
    end
    // Scenarios take about 25k cycles; stop a hang at 100k
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        end_of_test;
    end
endmodule
